// ===== bench/usbe_endpoint_regs_sva.sv
// port assertions for the endpoint register block
`timescale 1ns/1ns
`default_nettype none
module usbe_ep_sva
  import usbe_pkg::*;
(
  input wire logic              aclk,          // clock
  input wire logic              aresetn,       // reset
  input wire logic              s_axi_awready, // aw taken
  input wire logic              s_axi_bvalid,  // b valid
  input wire logic              s_axi_bready,  // b ready
  input wire logic              s_axi_arready, // ar taken
  input wire logic              s_axi_rvalid,  // r valid
  input wire logic              s_axi_rready,  // r ready
  input wire logic [31:0]       s_axi_rdata,   // r data
  input wire logic              link_tx_req,   // send req
  input wire usbe_byte_type     link_tx,       // sent byte
  input wire logic [NUM_EP-1:0] endpoint_irq   // irqs
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("no write answer");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("ar ready too long");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_data_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_tx_cause: assert property (link_tx.valid |-> $past(link_tx_req))
    else $error("byte sent unasked");
  a_irq_reset: assert property ($rose(aresetn) |-> endpoint_irq == '0)
    else $error("irq set after reset");
endmodule : usbe_ep_sva
bind usbe_endpoint_regs usbe_ep_sva chk (.*);
`default_nettype wire

// ===== bench/usbe_endpoint_regs_test.sv
// self-checking bench for the endpoint register block
`timescale 1ns/1ns
`default_nettype none
module usbe_endpoint_regs_test
  import usbe_pkg::*;
;
  // entries: endpoint, event bit, enable bit
  localparam logic [9:0] TBL [9] = '{10'h0c1, 10'h0a6, 10'h09c, 10'h080, 10'h0b7,
                                     10'h113, 10'h10a, 10'h0af, 10'h139};
  int miscompares = 0;
  int total_checks = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, link_tx_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [EP_W-1:0] link_tx_ep;
  logic [NUM_EP-1:0] endpoint_irq;
  usbe_event_type link_event;
  usbe_byte_type link_rx, link_tx;
  usbe_endpoint_regs #(.FIFO_DEPTH(8)) uut (.*, .usb_bus_reset(1'b0), .s_axi_wstrb(4'h1));
  usbe_host_model host (.*);
  always #25 aclk = ~aclk;
  task automatic chk(input logic [8:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, 24'h0, d, 3'h7};
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, e);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata[7:0], e);
  endtask : rc
  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    logic [2:0] e, n;
    logic [3:0] b;
    logic [8:0] g;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_ENABLES, 8'h00);
    wr(OFS_SELECT, 8'h01);
    wr(OFS_DIR, 8'h01);
    wr(OFS_ENABLES, 8'hff);
    rc(OFS_ENABLES, 8'hdf);
    foreach (TBL[i]) begin
      {e, b, n} = TBL[i];
      wr(OFS_SELECT, {5'h0, e});
      wr(OFS_ENABLES, 8'h00);
      host.fire(e, 9'h001 << b);
      repeat (2) @(posedge aclk);
      chk(endpoint_irq[e], 1'b0);
      wr(OFS_ENABLES, 8'h01 << n);
      repeat (2) @(posedge aclk);
      chk(endpoint_irq[e], 1'b1);
      rc(OFS_SUMMARY, 8'h01 << e);
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_FLOW, 8'h00);
      rc(OFS_SUMMARY, 8'h00);
    end
    $display("flag and enable test done");
    host.fire(3'h2, 9'h001);
    rc(OFS_FLAGS, 8'h00);
    host.put(3'h2, 8'ha5);
    host.put(3'h2, 8'h3c);
    rc(OFS_CNT_LO, 8'h02);
    rc(OFS_FIFO, 8'ha5);
    rc(OFS_CNT_LO, 8'h01);
    rc(OFS_CNT_HI, 8'h00);
    wr(OFS_SELECT, 8'h01);
    wr(OFS_FIFO, 8'h5a);
    wr(OFS_FIFO, 8'hc3);
    rc(OFS_CNT_LO, 8'h02);
    host.get(3'h1, g);
    chk(g, 9'h15a);
    rc(OFS_CNT_LO, 8'h01);
    wr(OFS_FLAGS, 8'h04);
    rc(OFS_CNT_LO, 8'h00);
    rc(8'h40, 8'h00);
    chk({s_axi_bresp, s_axi_rresp}, {RESP_OKAY, RESP_SLVERR});
    $display("fifo and count test done");
    finish_test();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule : usbe_endpoint_regs_test
`default_nettype wire

// ===== bench/usbe_host_model.sv
// host side model: link events, bytes in and bytes out
`timescale 1ns/1ns
`default_nettype none
module usbe_host_model
  import usbe_pkg::*;
(
  input  wire logic          aclk,        // clock
  output var usbe_event_type link_event,  // event pulses
  output var usbe_byte_type  link_rx,     // byte to device
  output logic               link_tx_req, // send request
  output logic [EP_W-1:0]    link_tx_ep,  // send endpoint
  input  wire usbe_byte_type link_tx      // byte from device
);
  initial {link_event, link_rx, link_tx_req, link_tx_ep} = '0;
  task automatic fire(input logic [EP_W-1:0] ep, input logic [8:0] bits);
    @(posedge aclk);
    link_event <= {ep, bits};
    @(posedge aclk);
    link_event <= '0;
  endtask : fire
  // released data shows the inverse, never a stale copy
  task automatic put(input logic [EP_W-1:0] ep, input logic [7:0] d);
    @(posedge aclk);
    link_rx <= {1'b1, ep, d};
    @(posedge aclk);
    link_rx <= {1'b0, ep, ~d};
  endtask : put
  task automatic get(input logic [EP_W-1:0] ep, output logic [8:0] b);
    @(posedge aclk);
    {link_tx_req, link_tx_ep} <= {1'b1, ep};
    @(posedge aclk);
    {link_tx_req, link_tx_ep} <= {1'b0, ~ep};
    #1 b = {link_tx.valid, link_tx.data};
  endtask : get
endmodule : usbe_host_model
`default_nettype wire

// ===== verilog/usbe_endpoint_regs.sv
// endpoint flags, enables, fifo data port and byte counts behind an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
// Operation
// (R01) Writing one to discard request drops the IN fifo content, then self-clears.
// (R02) Stall flag set on STALL sent or iso OUT CRC error; firmware clears only.
// (R03) Tx ready flag set when bank free, raises interrupt if enabled, held.
// (R04) Tx ready flag inactive and reads zero on OUT endpoints.
// (R05) Enable bit 7 gates overflow and underflow onto the endpoint interrupt.
// (R06) Enable bit 6 gates the NAK-on-IN flag.
// (R07) Enable bit 5 is reserved and reads zero.
// (R08) Enable bit 4 gates the NAK-on-OUT flag.
// (R09) Enable bit 3 gates the received SETUP flag.
// (R10) Enable bit 2 gates the received OUT data flag.
// (R11) Enable bit 1 gates the stall flag.
// (R12) Enable bit 0 gates the tx ready flag.
// (R13) Byte data port reads or writes the fifo of the selected endpoint.
// (R14) Eleven-bit count: upper three bits in high register, lower eight low.
// (R15) IN count rises on firmware write, falls on each byte sent.
// (R16) OUT count rises on each byte received, falls on firmware read.
// (R17) Summary bits 6:0 follow each endpoint interrupt; bit 7 reads zero.
// (R18) Overflow and underflow flags set by errors, cleared by firmware only.
// (R19) Discard request shares bit 2 with the received OUT data flag.
// (R20) NAK-on-IN and NAK-on-OUT flags set after NAK answers, firmware clears.
// (R21) Endpoint interrupt is OR of enabled flags; enables reset to zero.
module usbe_endpoint_regs
  import usbe_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic                  aclk,          // controller clock
  input  wire logic                  aresetn,       // sync reset, active low
  input  wire logic                  usb_bus_reset, // usb bus reset seen
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,  // write address
  input  wire logic                  s_axi_awvalid, // write address valid
  output logic                       s_axi_awready, // write address ready
  input  wire logic [31:0]           s_axi_wdata,   // write data
  input  wire logic [3:0]            s_axi_wstrb,   // write strobes
  input  wire logic                  s_axi_wvalid,  // write data valid
  output logic                       s_axi_wready,  // write data ready
  output logic [1:0]                 s_axi_bresp,   // write response
  output logic                       s_axi_bvalid,  // write response valid
  input  wire logic                  s_axi_bready,  // write response ready
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,  // read address
  input  wire logic                  s_axi_arvalid, // read address valid
  output logic                       s_axi_arready, // read address ready
  output logic [31:0]                s_axi_rdata,   // read data
  output logic [1:0]                 s_axi_rresp,   // read response
  output logic                       s_axi_rvalid,  // read data valid
  input  wire logic                  s_axi_rready,  // read data ready
  input  wire usbe_event_type        link_event,    // handshake events
  input  wire usbe_byte_type         link_rx,       // byte from host
  input  wire logic                  link_tx_req,   // request byte to send
  input  wire logic [EP_W-1:0]       link_tx_ep,    // endpoint to send from
  output usbe_byte_type              link_tx,       // byte to host
  output logic [NUM_EP-1:0]          endpoint_irq   // per endpoint interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                    awready_reg;
  logic                    wready_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    arready_reg;
  logic                    rvalid_reg;
  logic [1:0]              rresp_reg;
  logic [31:0]             rdata_reg;
  logic [EP_W-1:0]         endpoint_select_reg;
  logic [NUM_EP-1:0]       dir_in_reg;
  logic [NUM_EP-1:0]       irq_reg;
  usbe_byte_type           tx_reg;

  logic                    wr_fire;
  logic                    rd_fire;
  logic                    wr_byte;
  logic                    sel_ok;
  logic                    wr_map;
  logic                    rd_map;
  logic [7:0]              wbyte;
  logic [7:0]              rd_byte;

  logic [NUM_EP-1:0]       ep_wr_flags;
  logic [NUM_EP-1:0]       ep_wr_enables;
  logic [NUM_EP-1:0]       ep_wr_flow;
  logic [NUM_EP-1:0]       ep_fw_push;
  logic [NUM_EP-1:0]       ep_fw_pop;
  logic [NUM_EP-1:0]       ep_kill;
  logic [NUM_EP-1:0]       ep_irq;
  logic [NUM_EP-1:0]       ep_full;
  logic [7:0]              ep_flags   [NUM_EP];
  logic [7:0]              ep_enables [NUM_EP];
  logic [7:0]              ep_flow    [NUM_EP];
  logic [7:0]              ep_head    [NUM_EP];
  logic [CNT_W-1:0]        ep_count   [NUM_EP];

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  assign wr_fire = s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign wr_byte = wr_fire && s_axi_wstrb[0];
  assign wbyte   = s_axi_wdata[7:0];
  assign sel_ok  = (endpoint_select_reg < EP_W'(NUM_EP));

  // address and data are taken together, one cycle after both are offered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else if (wr_fire) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_wvalid && !bvalid_reg) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (s_axi_awaddr)
      OFS_SELECT, OFS_DIR, OFS_FLAGS, OFS_ENABLES, OFS_FIFO, OFS_FLOW: wr_map = 1'b1;
      OFS_CNT_HI, OFS_CNT_LO, OFS_SUMMARY: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  // an unused endpoint number reads zero everywhere except select and summary
  always_comb begin
    rd_map  = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      OFS_SELECT: begin
        rd_byte = {5'h00, endpoint_select_reg};
      end
      OFS_DIR: begin
        rd_byte = {7'h00, sel_ok && dir_in_reg[endpoint_select_reg]};
      end
      OFS_FLAGS: begin
        rd_byte = sel_ok ? ep_flags[endpoint_select_reg] : 8'h00;
      end
      OFS_ENABLES: begin
        rd_byte = sel_ok ? ep_enables[endpoint_select_reg] : 8'h00;
      end
      // (R13) data port read
      OFS_FIFO: begin
        rd_byte = sel_ok ? ep_head[endpoint_select_reg] : 8'h00;
      end
      // (R14) count split over two registers
      OFS_CNT_HI: begin
        rd_byte = sel_ok ? {5'h00, ep_count[endpoint_select_reg][CNT_W-1:8]} : 8'h00;
      end
      OFS_CNT_LO: begin
        rd_byte = sel_ok ? ep_count[endpoint_select_reg][7:0] : 8'h00;
      end
      // (R17) summary with bit seven zero
      OFS_SUMMARY: begin
        rd_byte = {1'b0, irq_reg};
      end
      OFS_FLOW: begin
        rd_byte = sel_ok ? ep_flow[endpoint_select_reg] : 8'h00;
      end
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // selector and direction
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      endpoint_select_reg <= RST_SELECT;
    end else if (wr_byte && s_axi_awaddr == OFS_SELECT) begin
      endpoint_select_reg <= wbyte[EP_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_in_reg <= '0;
    end else if (wr_byte && s_axi_awaddr == OFS_DIR && sel_ok) begin
      dir_in_reg[endpoint_select_reg] <= wbyte[0];
    end
  end

  // ----------------------------------------------------------------
  // per endpoint logic
  // ----------------------------------------------------------------
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    logic       hit;
    logic       is_ev;
    logic       is_in;
    logic       link_push;
    logic       link_pop;
    logic       access_ok;
    logic [7:0] hw_set;
    logic [1:0] flow_set;

    assign hit   = sel_ok && (endpoint_select_reg == EP_W'(e));
    assign is_ev = (link_event.ep == EP_W'(e));
    assign is_in = dir_in_reg[e];

    assign ep_wr_flags[e]   = wr_byte && hit && (s_axi_awaddr == OFS_FLAGS);
    assign ep_wr_enables[e] = wr_byte && hit && (s_axi_awaddr == OFS_ENABLES);
    assign ep_wr_flow[e]    = wr_byte && hit && (s_axi_awaddr == OFS_FLOW);
    // (R13) data port write goes to the IN fifo, read pops the OUT fifo
    assign ep_fw_push[e]    = wr_byte && hit && is_in && (s_axi_awaddr == OFS_FIFO);
    assign ep_fw_pop[e]     = rd_fire && hit && !is_in && (s_axi_araddr == OFS_FIFO);
    // (R16) host bytes fill OUT fifos
    assign link_push = link_rx.valid && (link_rx.ep == EP_W'(e)) && !is_in;
    // (R15) sent bytes drain IN fifos
    assign link_pop  = link_tx_req && (link_tx_ep == EP_W'(e)) && is_in;
    assign access_ok = is_in ? !ep_full[e] : (ep_count[e] != '0);

    always_comb begin
      hw_set = 8'h00;
      // (R20) nak answers
      hw_set[BIT_NAK_IN]   = is_ev && link_event.nak_in;
      hw_set[BIT_NAK_OUT]  = is_ev && link_event.nak_out;
      hw_set[BIT_SETUP]    = is_ev && link_event.setup;
      // (R19) new OUT packet in bank
      hw_set[BIT_OUT_RX]   = is_ev && link_event.out_bank;
      // (R02) stall sent or iso crc error
      hw_set[BIT_STALL]    = is_ev && (link_event.stall || link_event.crc_iso);
      // (R03) bank free for filling
      hw_set[BIT_TX_READY] = is_ev && link_event.bank_free;
      // (R18) iso flow errors
      flow_set = {is_ev && link_event.overflow, is_ev && link_event.underflow};
    end

    usbe_ep_flags u_flags (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .bus_reset  (usb_bus_reset),
      .is_in      (is_in),
      .hw_set     (hw_set),
      .flow_set   (flow_set),
      .wr_flags   (ep_wr_flags[e]),
      .wr_enables (ep_wr_enables[e]),
      .wr_flow    (ep_wr_flow[e]),
      .wdata      (wbyte),
      .access_ok  (access_ok),
      .flags_rd   (ep_flags[e]),
      .enables_rd (ep_enables[e]),
      .flow_rd    (ep_flow[e]),
      .kill       (ep_kill[e]),
      .irq        (ep_irq[e])
    );

    usbe_ep_fifo #(
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      // (R01) discard unsent content
      .flush     (usb_bus_reset || ep_kill[e]),
      .push      (is_in ? ep_fw_push[e] : link_push),
      .push_data (is_in ? wbyte : link_rx.data),
      .pop       (is_in ? link_pop : ep_fw_pop[e]),
      .head      (ep_head[e]),
      .count     (ep_count[e]),
      .full      (ep_full[e])
    );
  end

  // ----------------------------------------------------------------
  // interrupt summary and transmit byte
  // ----------------------------------------------------------------
  // (R17) summary follows gated sources, clears once they are serviced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= ep_irq;
    end
  end

  // byte leaves one cycle after its request; an empty fifo answers invalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reg <= '0;
    end else begin
      tx_reg.valid <= link_tx_req && (link_tx_ep < EP_W'(NUM_EP))
                   && dir_in_reg[link_tx_ep] && (ep_count[link_tx_ep] != '0);
      tx_reg.ep    <= link_tx_ep;
      tx_reg.data  <= (link_tx_ep < EP_W'(NUM_EP)) ? ep_head[link_tx_ep] : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign link_tx       = tx_reg;
  assign endpoint_irq  = irq_reg;

endmodule : usbe_endpoint_regs
`default_nettype wire

// ===== verilog/usbe_ep_fifo.sv
// byte fifo of one endpoint with its byte counter
`timescale 1ns/1ns
`default_nettype none
module usbe_ep_fifo
  import usbe_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic             aclk,      // controller clock
  input  wire logic             aresetn,   // sync reset, active low
  input  wire logic             flush,     // drop all content
  input  wire logic             push,      // write one byte
  input  wire logic [7:0]       push_data, // byte written
  input  wire logic             pop,       // drop head byte
  output logic      [7:0]       head,      // oldest byte
  output logic      [CNT_W-1:0] count,     // bytes held
  output logic                  full       // no room left
);
  localparam int PW = $clog2(DEPTH);

  logic [7:0]       mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             do_push;
  logic             do_pop;

  assign full    = (count_reg == CNT_W'(DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && (count_reg != '0);
  assign head    = mem[rd_ptr_reg];
  assign count   = count_reg;

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      // (R15) count up and down
      count_reg <= count_reg + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule : usbe_ep_fifo
`default_nettype wire

// ===== verilog/usbe_ep_flags.sv
// event flags, enables and interrupt gate of one endpoint
`timescale 1ns/1ns
`default_nettype none
module usbe_ep_flags
  import usbe_pkg::*;
(
  input  wire logic       aclk,        // controller clock
  input  wire logic       aresetn,     // sync reset, active low
  input  wire logic       bus_reset,   // usb bus reset
  input  wire logic       is_in,       // endpoint is IN
  input  wire logic [7:0] hw_set,      // flag set pulses
  input  wire logic [1:0] flow_set,    // overflow, underflow pulses
  input  wire logic       wr_flags,    // firmware writes flags
  input  wire logic       wr_enables,  // firmware writes enables
  input  wire logic       wr_flow,     // firmware writes flow status
  input  wire logic [7:0] wdata,       // firmware byte
  input  wire logic       access_ok,   // fifo access allowed
  output logic      [7:0] flags_rd,    // flag register view
  output logic      [7:0] enables_rd,  // enable register view
  output logic      [7:0] flow_rd,     // flow status view
  output logic            kill,        // discard bank now
  output logic            irq          // gated endpoint interrupt
);
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] set_eff;
  logic [7:0] en_reg;
  logic [1:0] flow_reg;
  logic [1:0] flow_next;
  logic       discard_bank_req_reg;

  always_comb begin
    set_eff = hw_set;
    // (R04) no tx ready on OUT
    set_eff[BIT_TX_READY] = hw_set[BIT_TX_READY] && is_in;
    set_eff[BIT_SETUP]    = hw_set[BIT_SETUP] && !is_in;
    set_eff[BIT_OUT_RX]   = hw_set[BIT_OUT_RX] && !is_in;
    flag_next = flag_reg;
    // (R02) zero clears, one ignored
    if (wr_flags) begin
      flag_next = flag_reg & (wdata | ~FLAG_CLR_MASK);
    end
    // set wins over a clear in the same cycle
    flag_next = (flag_next | set_eff) & FLAG_CLR_MASK;
    flow_next = flow_reg;
    // (R18) flow flags clear by zero
    if (wr_flow) begin
      flow_next = flow_reg & {wdata[BIT_OVER], wdata[BIT_UNDER]};
    end
    flow_next = flow_next | flow_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || bus_reset) begin
      flag_reg <= RST_FLAGS;
      flow_reg <= RST_FLOW;
    end else begin
      flag_reg <= flag_next;
      flow_reg <= flow_next;
    end
  end

  // (R01) self clearing discard request
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_reset) begin
      discard_bank_req_reg <= 1'b0;
    end else begin
      discard_bank_req_reg <= wr_flags && is_in && wdata[BIT_KILL];
    end
  end

  // (R07) reserved enable stays zero
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_reset) begin
      en_reg <= RST_ENABLES;
    end else if (wr_enables) begin
      en_reg <= wdata & EN_WR_MASK;
    end
  end

  always_comb begin
    flags_rd = flag_reg;
    flags_rd[BIT_ACCESS] = access_ok;
    // (R19) shared bit two
    flags_rd[BIT_OUT_RX] = is_in ? discard_bank_req_reg : flag_reg[BIT_OUT_RX];
    // (R04) reads zero on OUT
    flags_rd[BIT_TX_READY] = flag_reg[BIT_TX_READY] && is_in;
    flow_rd = 8'h00;
    flow_rd[BIT_OVER]  = flow_reg[1];
    flow_rd[BIT_UNDER] = flow_reg[0];
  end

  assign enables_rd = en_reg;
  assign kill       = discard_bank_req_reg;
  // (R21) or of gated flags; (R06) (R08) (R09) (R10) (R11) (R12) per-flag gates
  // (R05) flow errors gated by bit seven
  assign irq = (|({flags_rd[7:3], flag_reg[BIT_OUT_RX], flags_rd[1:0]} & en_reg & EN_FLAG_MASK))
             || ((|flow_reg) && en_reg[BIT_FLOW_EN]);
endmodule : usbe_ep_flags
`default_nettype wire

// ===== verilog/usbe_pkg.sv
// shared constants and carrier types of the endpoint flag and fifo access block
package usbe_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_EP   = 7;
  localparam int EP_W     = 3;
  localparam int CNT_W    = 11;
  localparam int AXI_AW   = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_SELECT  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_DIR     = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_FLAGS   = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_ENABLES = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_FIFO    = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_CNT_HI  = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_CNT_LO  = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_SUMMARY = 8'h1c;
  localparam logic [AXI_AW-1:0] OFS_FLOW    = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_NAK_IN   = 6;
  localparam int BIT_ACCESS   = 5;
  localparam int BIT_NAK_OUT  = 4;
  localparam int BIT_SETUP    = 3;
  localparam int BIT_OUT_RX   = 2;
  localparam int BIT_KILL     = 2;
  localparam int BIT_STALL    = 1;
  localparam int BIT_TX_READY = 0;
  localparam int BIT_FLOW_EN  = 7;
  localparam int BIT_OVER     = 6;
  localparam int BIT_UNDER    = 5;

  // flag bits that firmware may clear by writing zero
  localparam logic [7:0] FLAG_CLR_MASK = 8'h5f;
  // enable bits that take part in the per-flag gate
  localparam logic [7:0] EN_FLAG_MASK  = 8'h5f;
  localparam logic [7:0] EN_WR_MASK    = 8'hdf;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]      RST_FLAGS   = 8'h00;
  localparam logic [7:0]      RST_ENABLES = 8'h00;
  localparam logic [1:0]      RST_FLOW    = 2'h0;
  localparam logic [EP_W-1:0] RST_SELECT  = 3'h0;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [EP_W-1:0] ep;
    logic            stall;
    logic            crc_iso;
    logic            overflow;
    logic            underflow;
    logic            nak_in;
    logic            nak_out;
    logic            setup;
    logic            out_bank;
    logic            bank_free;
  } usbe_event_type;

  typedef struct packed {
    logic            valid;
    logic [EP_W-1:0] ep;
    logic [7:0]      data;
  } usbe_byte_type;

endpackage : usbe_pkg
